// ==== logic/phy_link_cfg.svh ====
`ifndef PHY_LINK_CFG_SVH
`define PHY_LINK_CFG_SVH

// ------------------------------------------------------------------
// Register numbers on the management path
// ------------------------------------------------------------------
`define REG_FIFO_OVF       5'h10
`define REG_LINK_PM        5'h11
`define REG_INBAND_CTRL    5'h12
`define REG_ACK_TIMEOUTS   5'h14
`define REG_EXIT_TIMEOUTS  5'h15

// ------------------------------------------------------------------
// Reset values and writable masks
// ------------------------------------------------------------------
`define FIFO_OVF_RO_VAL    16'h0200
`define LINK_PM_RST        16'h9284
`define LINK_PM_WMASK      16'h63FF
`define INBAND_CTRL_RST    16'h0507
`define ACK_TIMEOUTS_RST   16'h5504
`define EXIT_TIMEOUTS_RST  16'h0514

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define BIT_RX_OVF         8
`define BIT_TX_OVF         6
`define BIT_LP_EN          14
`define BIT_GIG_LP_BLOCK   13
`define BIT_CLKREQ_LP      9
`define BIT_PLL_STOP_GIG   8
`define BIT_PLL_KEEP_LOW   7
`define BIT_GIG_MSG_DIS    7
`define FLD_STATUS_PER     13:8
`define FLD_MAX_RETRY      6:0
`define FLD_MGMT_ACK_TO    15:8
`define FLD_STAT_ACK_TO    5:0
`define FLD_EXIT_IDLE      11:6

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define CLK_NS             40
`define US_NS              1000
`define EXIT_UNIT_NS       80
`define US_CYC             ((`US_NS + `CLK_NS - 1) / `CLK_NS)
`define EXIT_UNIT_CYC      ((`EXIT_UNIT_NS + `CLK_NS - 1) / `CLK_NS)
`define SMBUS_SCALE        1000
`define TEN_US_TICKS       10

`endif

// ==== logic/phy_link_pkg.sv ====
package phy_link_pkg;

	// Link power state, one-hot
	typedef enum logic [2:0] {
		LP_ACTIVE = 3'b001,
		LP_SLEEP  = 3'b010,
		LP_EXIT   = 3'b100
	} lp_state_e;

	// In-band message sequencer, one-hot
	typedef enum logic [1:0] {
		MSG_IDLE = 2'b01,
		MSG_WAIT = 2'b10
	} msg_state_e;

	// Link speed encoding
	typedef logic [1:0] speed_t;

endpackage

// ==== logic/phy_mac_link_power_control.sv ====
`timescale 1ns/1ns
`include "phy_link_cfg.svh"

// Notes on behaviour
// - Receive FIFO overflow sets read-only bit 8; cleared by read, reset zero.
// - Transmit FIFO overflow sets read-only bit 6; cleared by read, reset zero.
// - Low-power link state entered only while enable bit 14 is one.
// - Bit 13 set forbids low-power entry while link runs at gigabit speed.
// - Bit 9 set keeps clock request asserted during low-power state.
// - Bit 8 set stops serializer PLL in low-power state at gigabit speed.
// - At 10/100 speed bit 7 clear stops the PLL; set keeps it running.
// - Bit 0 is reserved; no idle entry on cable disconnect.
// - SMBus mode clears low-power enable; controller must rewrite it afterwards.
// - Link status resent every bits 13:8 times ten microseconds.
// - Bit 7 blocks gigabit in-band messages inside packets at 10/100.
// - Unacknowledged message retransmitted at most bits 6:0 times.
// - Management message acknowledge timeout is bits 15:8 microseconds.
// - Status message acknowledge timeout is bits 5:0 microseconds.
// - In SMBus mode every in-band timeout is a thousand times longer.
module phy_mac_link_power_control
	import phy_link_pkg::*;
#(
	parameter int CLK_PERIOD_NS = `CLK_NS,
	parameter int SMBUS_SCALE   = `SMBUS_SCALE
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// Management register access
	input  wire logic [4:0]  i_reg_addr,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [15:0] i_reg_wdata,
	output logic      [15:0] o_reg_rdata,
	// FIFO events
	input  wire logic        i_rx_fifo_ovf,
	input  wire logic        i_tx_fifo_ovf,
	// Link conditions
	input  wire logic        i_smbus_mode,
	input  wire speed_t      i_link_speed,
	input  wire logic        i_lowpower_req,
	input  wire logic        i_packet_active,
	// Low-power link control
	output logic             o_link_low_power_state,
	output logic             o_clk_req,
	output logic             o_pll_stop,
	output logic             o_idle_tx,
	output logic             o_data_tx_en,
	// In-band messages
	input  wire logic        i_msg_req,
	input  wire logic        i_msg_is_mgmt,
	input  wire logic        i_msg_ack,
	output logic             o_msg_send,
	output logic             o_msg_abandon,
	output logic             o_msg_busy,
	output logic             o_status_tx,
	output logic             o_gig_msg_allowed
);

	// Derived cycle counts; the exit counter is only eight bits wide
	localparam int US_CYC   = (`US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int UNIT_CYC = (`EXIT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Parameter checks; the idle phase needs two cycles per unit at least
	if (CLK_PERIOD_NS < 1 || CLK_PERIOD_NS > `US_NS || SMBUS_SCALE < 1 ||
		SMBUS_SCALE > 1023 || UNIT_CYC < 2 || UNIT_CYC * 6'h3F > 8'hFF) begin : g_bad
		$error("phy_mac_link_power_control: unsupported clock period or scale");
	end

	// Gigabit decode, shared by power and message logic
	function automatic logic speed_is_gig(input speed_t s);
		speed_is_gig = (s == 2'h2);
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [15:0] pm_r;
	logic [15:0] inband_r;
	logic [15:0] ackto_r;
	logic [15:0] exitto_r;
	logic        rx_ovf_r, tx_ovf_r;
	logic        smb_meta_r, smb_r;
	logic [9:0]  us_cnt_r;
	logic [9:0]  ms_cnt_r;
	logic [3:0]  ten_cnt_r;
	logic [5:0]  per_cnt_r;
	logic [7:0]  exit_cnt_r;
	logic [7:0]  to_cnt_r;
	logic [6:0]  retry_r;
	logic        kind_r;
	lp_state_e   lp_r;
	msg_state_e  msg_r;
	logic        us_tick, ms_tick, to_tick, ten_tick;
	logic        gig, lp_allow;
	logic [7:0]  to_limit;
	logic        to_expire;
	logic        rd_fifo;

	assign gig = speed_is_gig(i_link_speed);

	// ------------------------------------------------------------------
	// SMBus mode synchroniser; strap pin is asynchronous
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			smb_meta_r <= 1'b0;
			smb_r      <= 1'b0;
		end else begin
			smb_meta_r <= i_smbus_mode;
			smb_r      <= smb_meta_r;
		end
	end

	// ------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------
	// Power control; SMBus clear beats a write so enable cannot stick
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pm_r <= `LINK_PM_RST;
		end else begin
			if (i_reg_wr && i_reg_addr == `REG_LINK_PM) begin
				pm_r <= (i_reg_wdata & `LINK_PM_WMASK) | (`LINK_PM_RST & ~`LINK_PM_WMASK);
			end
			if (smb_r) begin
				pm_r[`BIT_LP_EN] <= 1'b0;
			end
		end
	end

	// Plain read/write registers; reserved bits stored as written
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			inband_r <= `INBAND_CTRL_RST;
			ackto_r  <= `ACK_TIMEOUTS_RST;
			exitto_r <= `EXIT_TIMEOUTS_RST;
		end else if (i_reg_wr) begin
			if (i_reg_addr == `REG_INBAND_CTRL) begin
				inband_r <= i_reg_wdata;
			end
			if (i_reg_addr == `REG_ACK_TIMEOUTS) begin
				ackto_r <= i_reg_wdata;
			end
			if (i_reg_addr == `REG_EXIT_TIMEOUTS) begin
				exitto_r <= i_reg_wdata;
			end
		end
	end

	// Overflow flags: set wins over the read that clears them
	assign rd_fifo = i_reg_rd && i_reg_addr == `REG_FIFO_OVF;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rx_ovf_r <= 1'b0;
			tx_ovf_r <= 1'b0;
		end else begin
			rx_ovf_r <= i_rx_fifo_ovf | (rx_ovf_r & ~rd_fifo);
			tx_ovf_r <= i_tx_fifo_ovf | (tx_ovf_r & ~rd_fifo);
		end
	end

	// Register reads, registered one cycle after the strobe
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_reg_rdata <= 16'h0000;
		end else if (i_reg_rd) begin
			unique case (i_reg_addr)
				`REG_FIFO_OVF: begin
					o_reg_rdata                <= `FIFO_OVF_RO_VAL;
					o_reg_rdata[`BIT_RX_OVF]   <= rx_ovf_r;
					o_reg_rdata[`BIT_TX_OVF]   <= tx_ovf_r;
				end
				`REG_LINK_PM:       o_reg_rdata <= pm_r;
				`REG_INBAND_CTRL:   o_reg_rdata <= inband_r;
				`REG_ACK_TIMEOUTS:  o_reg_rdata <= ackto_r;
				`REG_EXIT_TIMEOUTS: o_reg_rdata <= exitto_r;
				default:            o_reg_rdata <= 16'h0000;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Time base: microsecond tick, SMBus scale, ten-unit tick
	// ------------------------------------------------------------------
	assign us_tick  = (us_cnt_r == 10'(US_CYC - 1));
	assign ms_tick  = us_tick && (ms_cnt_r == 10'(SMBUS_SCALE - 1));
	assign to_tick  = smb_r ? ms_tick : us_tick;
	assign ten_tick = to_tick && (ten_cnt_r == 4'(`TEN_US_TICKS - 1));

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			us_cnt_r  <= 10'h000;
			ms_cnt_r  <= 10'h000;
			ten_cnt_r <= 4'h0;
		end else begin
			us_cnt_r <= us_tick ? 10'h000 : us_cnt_r + 10'h001;
			if (us_tick) begin
				ms_cnt_r <= ms_tick ? 10'h000 : ms_cnt_r + 10'h001;
			end
			if (to_tick) begin
				ten_cnt_r <= ten_tick ? 4'h0 : ten_cnt_r + 4'h1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Low-power link state machine
	// ------------------------------------------------------------------
	// Gigabit block checked only at entry; a zero exit time skips the idle phase
	assign lp_allow = pm_r[`BIT_LP_EN] && !(pm_r[`BIT_GIG_LP_BLOCK] && gig);

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			lp_r       <= LP_ACTIVE;
			exit_cnt_r <= 8'h00;
		end else begin
			unique case (lp_r)
				LP_ACTIVE: begin
					if (i_lowpower_req && lp_allow) begin
						lp_r <= LP_SLEEP;
					end
				end
				LP_SLEEP: begin
					if (!i_lowpower_req || !pm_r[`BIT_LP_EN]) begin
						exit_cnt_r <= 8'(exitto_r[`FLD_EXIT_IDLE] * UNIT_CYC);
						lp_r       <= (exitto_r[`FLD_EXIT_IDLE] == 6'h00) ? LP_ACTIVE : LP_EXIT;
					end
				end
				LP_EXIT: begin
					exit_cnt_r <= exit_cnt_r - 8'h01;
					if (exit_cnt_r == 8'h01) begin
						lp_r <= LP_ACTIVE;
					end
				end
			endcase
		end
	end

	// Power outputs; clock request stays up outside low power
	assign o_link_low_power_state = (lp_r == LP_SLEEP);
	assign o_clk_req    = (lp_r != LP_SLEEP) || pm_r[`BIT_CLKREQ_LP];
	assign o_pll_stop   = (lp_r == LP_SLEEP) &&
		(gig ? pm_r[`BIT_PLL_STOP_GIG] : !pm_r[`BIT_PLL_KEEP_LOW]);
	assign o_idle_tx    = (lp_r == LP_EXIT);
	assign o_data_tx_en = (lp_r == LP_ACTIVE);

	// Periodic link status retransmission; zero period disables it
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			per_cnt_r   <= 6'h00;
			o_status_tx <= 1'b0;
		end else begin
			o_status_tx <= 1'b0;
			if (inband_r[`FLD_STATUS_PER] == 6'h00) begin
				per_cnt_r <= 6'h00;
			end else if (ten_tick) begin
				if (per_cnt_r + 6'h01 >= inband_r[`FLD_STATUS_PER]) begin
					per_cnt_r   <= 6'h00;
					o_status_tx <= 1'b1;
				end else begin
					per_cnt_r <= per_cnt_r + 6'h01;
				end
			end
		end
	end

	// Gigabit in-band messages barred inside packets at low speed
	assign o_gig_msg_allowed = !(inband_r[`BIT_GIG_MSG_DIS] && !gig && i_packet_active);

	// ------------------------------------------------------------------
	// In-band message acknowledge and retry
	// ------------------------------------------------------------------
	// Zero timeout still waits one tick, so a message is never dropped at once
	always_comb begin
		to_limit = kind_r ? ackto_r[`FLD_MGMT_ACK_TO]
			: {2'h0, ackto_r[`FLD_STAT_ACK_TO]};
		if (to_limit == 8'h00) begin
			to_limit = 8'h01;
		end
	end
	assign to_expire = (msg_r == MSG_WAIT) && to_tick && (to_cnt_r + 8'h01 >= to_limit);

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			msg_r         <= MSG_IDLE;
			kind_r        <= 1'b0;
			to_cnt_r      <= 8'h00;
			retry_r       <= 7'h00;
			o_msg_send    <= 1'b0;
			o_msg_abandon <= 1'b0;
		end else begin
			o_msg_send    <= 1'b0;
			o_msg_abandon <= 1'b0;
			unique case (msg_r)
				MSG_IDLE: begin
					if (i_msg_req) begin
						kind_r     <= i_msg_is_mgmt;
						to_cnt_r   <= 8'h00;
						retry_r    <= 7'h00;
						o_msg_send <= 1'b1;
						msg_r      <= MSG_WAIT;
					end
				end
				MSG_WAIT: begin
					if (i_msg_ack) begin
						msg_r <= MSG_IDLE;
					end else if (to_expire) begin
						to_cnt_r <= 8'h00;
						if (retry_r < inband_r[`FLD_MAX_RETRY]) begin
							retry_r    <= retry_r + 7'h01;
							o_msg_send <= 1'b1;
						end else begin
							o_msg_abandon <= 1'b1;
							msg_r         <= MSG_IDLE;
						end
					end else if (to_tick) begin
						to_cnt_r <= to_cnt_r + 8'h01;
					end
				end
			endcase
		end
	end
	assign o_msg_busy = (msg_r == MSG_WAIT);

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_sleep_to_exit;
		(lp_r == LP_SLEEP) ##1 (lp_r == LP_EXIT);
	endsequence

	sequence s_retry_send;
		(msg_r == MSG_WAIT) && to_expire && !i_msg_ack && (retry_r < inband_r[`FLD_MAX_RETRY]);
	endsequence

	AST_RX_OVF_HELD: assert property (i_rx_fifo_ovf |=> rx_ovf_r ##1 (rx_ovf_r || $past(rd_fifo)))
		else $error("rx overflow flag not held");
	AST_TX_OVF_CLEAR: assert property (tx_ovf_r && rd_fifo && !i_tx_fifo_ovf |=> !tx_ovf_r)
		else $error("tx overflow flag not cleared by read");
	AST_LP_ENTRY_EN: assert property ($rose(lp_r == LP_SLEEP) |-> $past(pm_r[`BIT_LP_EN]))
		else $error("low power entered while disabled");
	AST_GIG_NO_ENTRY: assert property ($rose(lp_r == LP_SLEEP) |-> !$past(pm_r[`BIT_GIG_LP_BLOCK] && gig))
		else $error("low power entered at gigabit while blocked");
	AST_CLKREQ_SLEEP: assert property ((lp_r == LP_SLEEP) && !pm_r[`BIT_CLKREQ_LP] |-> !o_clk_req)
		else $error("clock request wrong in low power");
	AST_PLL_LOW_SPEED: assert property ((lp_r == LP_SLEEP) && !gig |-> o_pll_stop == !pm_r[`BIT_PLL_KEEP_LOW])
		else $error("pll stop polarity wrong at low speed");
	AST_SMBUS_CLEAR: assert property (smb_r |=> !pm_r[`BIT_LP_EN] ##1 !pm_r[`BIT_LP_EN] || !smb_r)
		else $error("low power enable survived smbus mode");
	AST_EXIT_IDLE: assert property (s_sleep_to_exit |-> !o_data_tx_en && o_idle_tx ##1 !o_data_tx_en)
		else $error("data sent before idle period ended");
	AST_RETRY_SEND: assert property (s_retry_send |=> o_msg_send && o_msg_busy)
		else $error("retransmission missing after timeout");
	AST_ABANDON_LIMIT: assert property (o_msg_abandon |-> $past(retry_r) == inband_r[`FLD_MAX_RETRY] && !o_msg_busy)
		else $error("message abandoned before retry limit");
	AST_SMB_SCALE: assert property (smb_r && to_tick |-> ms_cnt_r == 10'(SMBUS_SCALE - 1))
		else $error("smbus timeout tick not scaled");
	AST_STATUS_PERIOD: assert property (o_status_tx |-> $past(inband_r[`FLD_STATUS_PER]) != 6'h00)
		else $error("status sent with period zero");

endmodule

// ==== test/mac_ack_model.sv ====
`timescale 1ns/1ns

// ------------------------------------------------------------------
// Controller side: answers each message send with an acknowledge while i_ack_en is set
// ------------------------------------------------------------------
module mac_ack_model (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	// Message traffic from the block
	input  wire logic       i_send,
	// Behaviour chosen by the bench
	input  wire logic       i_ack_en,
	input  wire logic [7:0] i_ack_delay,
	// Acknowledge back to the block
	output logic            o_ack
);
	logic [7:0] wait_r;
	logic       pend_r;

	// Delayed one-cycle acknowledge; silence when disabled forces retries
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pend_r <= 1'b0;
			wait_r <= 8'h00;
			o_ack  <= 1'b0;
		end else begin
			o_ack <= 1'b0;
			if (i_send && i_ack_en) begin
				pend_r <= 1'b1;
				wait_r <= i_ack_delay;
			end else if (pend_r && wait_r == 8'h00) begin
				o_ack  <= 1'b1;
				pend_r <= 1'b0;
			end else if (pend_r) begin
				wait_r <= wait_r - 8'h01;
			end
		end
	end
endmodule

// ==== test/phy_mac_link_power_control_test.sv ====
`timescale 1ns/1ns
`include "phy_link_cfg.svh"

module phy_mac_link_power_control_test
	import phy_link_pkg::*;
;
	localparam int SCALE = 3;
	localparam int LIMIT = 20000;
	logic        i_clk, i_rst_n, i_reg_wr, i_reg_rd, i_rx_fifo_ovf, i_tx_fifo_ovf;
	logic        i_smbus_mode, i_lowpower_req, i_packet_active, i_msg_req, i_msg_is_mgmt;
	logic [4:0]  i_reg_addr;
	logic [15:0] i_reg_wdata, o_reg_rdata;
	speed_t      i_link_speed;
	logic        o_link_low_power_state, o_clk_req, o_pll_stop, o_idle_tx, o_data_tx_en;
	logic        i_msg_ack, o_msg_send, o_msg_abandon, o_msg_busy, o_status_tx;
	logic        o_gig_msg_allowed, ack_en;
	int          failures, n_compared, cycles;

	// ------------------------------------------------------------------
	// Design, shortened SMBus scale, and controller model
	// ------------------------------------------------------------------
	phy_mac_link_power_control #(.SMBUS_SCALE(SCALE)) uut (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
		.i_rx_fifo_ovf(i_rx_fifo_ovf), .i_tx_fifo_ovf(i_tx_fifo_ovf),
		.i_smbus_mode(i_smbus_mode), .i_link_speed(i_link_speed),
		.i_lowpower_req(i_lowpower_req), .i_packet_active(i_packet_active),
		.o_link_low_power_state(o_link_low_power_state), .o_clk_req(o_clk_req),
		.o_pll_stop(o_pll_stop), .o_idle_tx(o_idle_tx), .o_data_tx_en(o_data_tx_en),
		.i_msg_req(i_msg_req), .i_msg_is_mgmt(i_msg_is_mgmt), .i_msg_ack(i_msg_ack),
		.o_msg_send(o_msg_send), .o_msg_abandon(o_msg_abandon), .o_msg_busy(o_msg_busy),
		.o_status_tx(o_status_tx), .o_gig_msg_allowed(o_gig_msg_allowed));
	mac_ack_model partner (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_send(o_msg_send),
		.i_ack_en(ack_en), .i_ack_delay(8'h04), .o_ack(i_msg_ack));

	// Clock, 40 ns period
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	// Hang guard
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			failures++;
			test_done();
		end
	end

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic step();
		@(posedge i_clk);
		#2;
	endtask

	task automatic test_done();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
		i_reg_addr  = a;
		i_reg_wdata = d;
		i_reg_wr    = 1'b1;
		step();
		i_reg_wr = 1'b0;
		step();
	endtask

	// Read data is registered, so it is taken one edge after the strobe
	task automatic reg_rd(input logic [4:0] a, output logic [15:0] v);
		i_reg_addr = a;
		i_reg_rd   = 1'b1;
		step();
		i_reg_rd = 1'b0;
		v = o_reg_rdata;
		step();
	endtask

	task automatic reg_chk(input logic [4:0] a, input logic [15:0] exp, input string name);
		logic [15:0] v;
		reg_rd(a, v);
		chk(name, exp, v);
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset_vals();
		reg_chk(`REG_FIFO_OVF, 16'h0200, "fifo_rst");
		reg_chk(`REG_LINK_PM, 16'h9284, "pm_rst");
		reg_chk(`REG_INBAND_CTRL, 16'h0507, "inband_rst");
		reg_chk(`REG_ACK_TIMEOUTS, 16'h5504, "ack_rst");
		reg_chk(`REG_EXIT_TIMEOUTS, 16'h0514, "exit_rst");
		reg_wr(5'h13, 16'hFFFF);
		reg_chk(5'h13, 16'h0000, "unmapped");
		chk("clk_req_rst", 16'h0001, 16'(o_clk_req));
	endtask

	task automatic t_overflow();
		i_rx_fifo_ovf = 1'b1;
		step();
		i_rx_fifo_ovf = 1'b0;
		reg_chk(`REG_FIFO_OVF, 16'h0300, "rx_ovf");
		reg_chk(`REG_FIFO_OVF, 16'h0200, "rx_ovf_clr");
		i_tx_fifo_ovf = 1'b1;
		step();
		i_tx_fifo_ovf = 1'b0;
		reg_chk(`REG_FIFO_OVF, 16'h0240, "tx_ovf");
		reg_wr(`REG_FIFO_OVF, 16'hFFFF);
		reg_chk(`REG_FIFO_OVF, 16'h0200, "fifo_ro");
	endtask

	// Request low power, check pins, release and count idle symbols (N=3)
	task automatic lp_try(input logic [15:0] w, input speed_t s, input logic e_lp,
		input logic e_clk, input logic e_pll);
		int n;
		reg_wr(`REG_LINK_PM, w);
		i_link_speed   = s;
		i_lowpower_req = 1'b1;
		repeat (3) step();
		chk("lp_state", 16'(e_lp), 16'(o_link_low_power_state));
		if (e_lp) begin
			chk("clk_req", 16'(e_clk), 16'(o_clk_req));
			chk("pll_stop", 16'(e_pll), 16'(o_pll_stop));
			chk("tx_en_lp", 16'h0000, 16'(o_data_tx_en));
		end
		i_lowpower_req = 1'b0;
		n = 0;
		for (int i = 0; i < 100 && o_data_tx_en !== 1'b1; i++) begin
			step();
			n += (o_idle_tx === 1'b1);
		end
		chk("exit_idle", e_lp ? 16'd6 : 16'd0, 16'(n));
	endtask

	task automatic t_lowpower();
		logic [15:0] v;
		reg_rd(`REG_EXIT_TIMEOUTS, v);
		reg_wr(`REG_EXIT_TIMEOUTS, {v[15:12], 6'd3, v[5:0]});
		lp_try(16'h0284, 2'b00, 1'b0, 1'b0, 1'b0);
		lp_try(16'h4284, 2'b00, 1'b1, 1'b1, 1'b0);
		lp_try(16'h4004, 2'b01, 1'b1, 1'b0, 1'b1);
		lp_try(16'h4104, 2'b10, 1'b1, 1'b0, 1'b1);
		lp_try(16'h4004, 2'b10, 1'b1, 1'b0, 1'b0);
		lp_try(16'h6004, 2'b10, 1'b0, 1'b0, 1'b0);
		lp_try(16'h6004, 2'b01, 1'b1, 1'b0, 1'b1);
	endtask

	task automatic t_smbus_clear();
		reg_wr(`REG_LINK_PM, 16'h4284);
		i_lowpower_req = 1'b1;
		repeat (3) step();
		i_smbus_mode = 1'b1;
		repeat (6) step();
		chk("lp_smbus", 16'h0000, 16'(o_link_low_power_state));
		reg_wr(`REG_LINK_PM, 16'h4284);
		reg_chk(`REG_LINK_PM, 16'h9284, "pm_smbus");
		i_smbus_mode = 1'b0;
		repeat (4) step();
		reg_chk(`REG_LINK_PM, 16'h9284, "pm_back");
		reg_wr(`REG_LINK_PM, 16'h4284);
		repeat (3) step();
		chk("lp_again", 16'h0001, 16'(o_link_low_power_state));
		i_lowpower_req = 1'b0;
		repeat (20) step();
	endtask

	task automatic gig_chk(input speed_t s, input logic p, input logic e);
		i_link_speed    = s;
		i_packet_active = p;
		step();
		chk("gig_msg", 16'(e), 16'(o_gig_msg_allowed));
	endtask

	task automatic t_gig_msg();
		reg_wr(`REG_INBAND_CTRL, 16'h0587);
		gig_chk(2'b00, 1'b1, 1'b0);
		gig_chk(2'b01, 1'b1, 1'b0);
		gig_chk(2'b01, 1'b0, 1'b1);
		gig_chk(2'b10, 1'b1, 1'b1);
		reg_wr(`REG_INBAND_CTRL, 16'h0507);
		gig_chk(2'b00, 1'b1, 1'b1);
		i_packet_active = 1'b0;
	endtask

	// Unacknowledged message: count sends and time to abandon
	task automatic t_msg(input logic mgmt, input int tmo, input int rty, input int sc);
		int sends, t, n;
		reg_wr(`REG_INBAND_CTRL, {8'h05, 1'b0, 7'(rty)});
		reg_wr(`REG_ACK_TIMEOUTS, mgmt ? {8'(tmo), 8'h04} : {8'h55, 2'b00, 6'(tmo)});
		i_msg_is_mgmt = mgmt;
		i_msg_req     = 1'b1;
		step();
		i_msg_req = 1'b0;
		sends = 0;
		t = 0;
		n = rty + 1;
		while (o_msg_abandon !== 1'b1 && t < 5000) begin
			sends += (o_msg_send === 1'b1);
			step();
			t++;
		end
		chk("sends", 16'(n), 16'(sends));
		chk("busy_end", 16'h0000, 16'(o_msg_busy));
		if (t < (n * tmo - 1) * 25 * sc || t > n * tmo * 25 * sc + 4) begin
			chk("abandon_time", 16'(n * tmo * 25 * sc), 16'(t));
		end
	endtask

	task automatic t_ack();
		int sends;
		ack_en = 1'b1;
		i_msg_req = 1'b1;
		step();
		sends = 0;
		for (int t = 0; t < 40; t++) begin
			i_msg_req = (t == 3);
			sends += (o_msg_send === 1'b1);
			chk("abandon_ack", 16'h0000, 16'(o_msg_abandon));
			step();
		end
		chk("ack_sends", 16'h0001, 16'(sends));
		chk("ack_busy", 16'h0000, 16'(o_msg_busy));
		ack_en = 1'b0;
	endtask

	// Period P=2 gives 20 ticks of 25 cycles between status sends
	task automatic t_status();
		int t;
		reg_wr(`REG_INBAND_CTRL, 16'h0207);
		for (int i = 0; i < 1500 && o_status_tx !== 1'b1; i++) begin
			step();
		end
		t = 0;
		step();
		while (o_status_tx !== 1'b1 && t < 1500) begin
			step();
			t++;
		end
		chk("status_per", 16'd499, 16'(t));
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		{i_reg_wr, i_reg_rd, i_rx_fifo_ovf, i_tx_fifo_ovf, i_smbus_mode} = '0;
		{i_lowpower_req, i_packet_active, i_msg_req, i_msg_is_mgmt, ack_en} = '0;
		i_reg_addr   = 5'h00;
		i_reg_wdata  = 16'h0000;
		i_link_speed = 2'b00;
		failures     = 0;
		n_compared   = 0;
		cycles       = 0;
		i_rst_n      = 1'b0;
		repeat (10) step();
		i_rst_n = 1'b1;
		t_reset_vals();
		t_overflow();
		t_lowpower();
		t_smbus_clear();
		t_gig_msg();
		t_msg(1'b0, 4, 2, 1);
		t_msg(1'b1, 2, 0, 1);
		t_ack();
		i_smbus_mode = 1'b1;
		repeat (4) step();
		t_msg(1'b0, 2, 0, SCALE);
		i_smbus_mode = 1'b0;
		repeat (4) step();
		t_status();
		test_done();
	end
endmodule
